// ---- rtl/pll_select_regs.vh ----
// register map, field layouts and reset values of the frequency-select control block
// Behaviour
// - select bits zero and one are captured from serial pins at start-up, then held.
// - by default, shutdown low tristates all clock outputs and stops active circuitry.
// - in output-enable-only mode, shutdown low only tristates outputs.
// - third select input is index bit two, or optionally the suspend control.
// - select index switches first PLL setting and output A and B dividers.
// - eight-entry frequency table indexed by live bit two and two latched bits.
// - outputs A and B share one control choosing divider register 0 or 1.
// - divider changes caused by select inputs take effect without output glitches.
// - each PLL output is reference divided by 8-bit Q times 11-bit P.
// - first PLL feeds cross-point and a /2, /3, /4 post-divider to output E.
// - first PLL frequency changes by programming or by the select inputs.
// - second and third PLLs feed only the cross-point, set by programming.
// - six-bit crystal load field, 0.375pF steps, 6 pF to 30 pF.
// - crystal inverter drive strength is selectable by programming.
// - load capacitors may be bypassed for a driven reference up to 166 MHz.
// - buffered-reference output carries a buffered copy of the reference.
// - select inputs determine the divider-select bit for outputs A and B.
// - suspend low shuts down a programmed set of outputs and PLLs, tristated.
`ifndef PLL_SELECT_REGS_VH
`define PLL_SELECT_REGS_VH

`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_OSC         12'h008
`define ADDR_OUTPUT_CLOCK_E        12'h00C
`define ADDR_SECOND_PLL        12'h010
`define ADDR_THIRD_PLL        12'h014
`define ADDR_SUSP        12'h018
`define ADDR_DIVC        12'h01C
`define ADDR_DIVD        12'h020
`define ADDR_TABLE_BASE  12'h040
`define ADDR_DIVA_BASE   12'h080
`define ADDR_DIVB_BASE   12'h088
`define ADDR_TABLE_MASK  12'hFE0
`define ADDR_DIV_MASK    12'hFF8

// control register fields
`define CTRL_OE_ONLY     0
`define CTRL_SUSP_MODE   1
`define CTRL_FIRST_PLL_EN     2
`define CTRL_SECOND_PLL_EN     3
`define CTRL_THIRD_PLL_EN     4
`define CTRL_RESET       32'h0000_001C

// oscillator register fields
`define OSC_CAP_LSB      0
`define OSC_CAP_MSB      5
`define OSC_DRV_LSB      8
`define OSC_DRV_MSB      9
`define OSC_BYPASS       12
`define OSC_RESET        32'h0000_0120

// frequency table entry: q[7:0], p[18:8], divider select [20]
`define TAB_Q_LSB        0
`define TAB_Q_MSB        7
`define TAB_P_LSB        8
`define TAB_P_MSB        18
`define TAB_DSEL         20
`define TAB_RESET        32'h0000_2001

// suspend mask: outputs a..e [4:0], buffered ref [5], plls 1..3 [10:8]
`define SUSP_PLL_LSB     8
`define SUSP_RESET       32'h0000_0000

`define DIV_RESET        7'h01
`define OUTPUT_CLOCK_E_RESET       2'h2
`define OUTPUT_CLOCK_E_OFF         2'h0
`define OUTPUT_CLOCK_E_DIV4        2'h1
`define OUTPUT_CLOCK_E_DIV2        2'h2
`define OUTPUT_CLOCK_E_DIV3        2'h3

`endif

// ---- rtl/pll_frequency_select_control.v ----
// control logic of a three-PLL clock generator with APB register access
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pll_select_regs.vh"

module pll_frequency_select_control (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        serial_port_data_pin,
    input  wire        serial_port_clock_pin,
    input  wire        select_bit_two,
    input  wire        shutdown_oe_n,
    output reg  [7:0]  first_pll_q,
    output reg  [10:0] first_pll_p,
    output reg  [7:0]  second_pll_q,
    output reg  [10:0] second_pll_p,
    output reg  [7:0]  third_pll_q,
    output reg  [10:0] third_pll_p,
    output reg  [2:0]  pll_enable,
    output reg  [6:0]  output_a_divider,
    output reg  [6:0]  output_b_divider,
    output reg  [6:0]  output_c_divider,
    output reg  [6:0]  output_d_divider,
    output reg  [1:0]  output_e_post_divider,
    output reg  [5:0]  crystal_load_cap,
    output reg  [1:0]  crystal_drive,
    output reg         load_cap_bypass,
    output reg         oscillator_enable,
    output reg         buffered_ref_enable,
    output reg  [4:0]  output_enable,
    output reg         divider_register_select
);

    reg  [31:0] ctrl;
    reg  [31:0] osc;
    reg  [31:0] susp;
    reg  [1:0]  output_clock_e_div;
    reg  [18:0] second_pll_cfg;
    reg  [18:0] third_pll_cfg;
    reg  [6:0]  div_c;
    reg  [6:0]  div_d;
    reg  [31:0] freq_table [0:7];
    reg  [6:0]  div_a [0:1];
    reg  [6:0]  div_b [0:1];

    // pin synchronisers
    reg  [1:0]  s0_sync;
    reg  [1:0]  s1_sync;
    reg  [1:0]  s2_sync;
    reg  [1:0]  sd_sync;
    reg  [1:0]  strap_wait;
    reg         strap_done;
    reg         select_bit_zero;
    reg         select_bit_one;

    wire        wr_en;
    wire        rd_en;
    wire [2:0]  freq_index;
    wire [31:0] entry;
    wire        suspended;
    wire        shut;
    wire        chip_down;
    wire        table_hit;
    wire        diva_hit;
    wire        divb_hit;
    wire [4:0]  next_output_enable;
    wire [2:0]  next_pll_enable;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;

    // address windows of the indexed register groups
    assign table_hit = (paddr & `ADDR_TABLE_MASK) == `ADDR_TABLE_BASE;
    assign diva_hit  = (paddr & `ADDR_DIV_MASK) == `ADDR_DIVA_BASE;
    assign divb_hit  = (paddr & `ADDR_DIV_MASK) == `ADDR_DIVB_BASE;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s0_sync <= 2'h0;
            s1_sync <= 2'h0;
            s2_sync <= 2'h0;
            sd_sync <= 2'h0;
        end else begin
            s0_sync <= {s0_sync[0], serial_port_data_pin};
            s1_sync <= {s1_sync[0], serial_port_clock_pin};
            s2_sync <= {s2_sync[0], select_bit_two};
            sd_sync <= {sd_sync[0], shutdown_oe_n};
        end
    end

    // strap capture once, on the third edge after reset release, when the
    // synchroniser has flushed its reset value and shows the real pin level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait      <= 2'h0;
            strap_done      <= 1'b0;
            select_bit_zero <= 1'b0;
            select_bit_one  <= 1'b0;
        end else begin
            strap_wait <= {strap_wait[0], 1'b1};
            if (strap_wait[1] && !strap_done) begin
                strap_done      <= 1'b1;
                select_bit_zero <= s0_sync[1];
                select_bit_one  <= s1_sync[1];
            end
        end
    end

    // bit two is an index bit only when not used for suspend
    assign freq_index = {(ctrl[`CTRL_SUSP_MODE] ? 1'b0 : s2_sync[1]),
                         select_bit_one, select_bit_zero};
    assign entry      = freq_table[freq_index];
    assign suspended  = ctrl[`CTRL_SUSP_MODE] & ~s2_sync[1];
    assign shut       = ~sd_sync[1];
    assign chip_down  = shut & ~ctrl[`CTRL_OE_ONLY];

    // register writes
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `CTRL_RESET;
            osc      <= `OSC_RESET;
            susp     <= `SUSP_RESET;
            output_clock_e_div <= `OUTPUT_CLOCK_E_RESET;
            second_pll_cfg <= 19'h0_2001;
            third_pll_cfg <= 19'h0_2001;
            div_c    <= `DIV_RESET;
            div_d    <= `DIV_RESET;
            for (i = 0; i < 8; i = i + 1) begin
                freq_table[i] <= `TAB_RESET;
            end
            for (i = 0; i < 2; i = i + 1) begin
                div_a[i] <= `DIV_RESET;
                div_b[i] <= `DIV_RESET;
            end
        end else if (wr_en) begin
            case (paddr)
                `ADDR_CTRL: ctrl     <= pwdata & 32'h0000_001F;
                `ADDR_OSC:  osc      <= pwdata & 32'h0000_133F;
                `ADDR_OUTPUT_CLOCK_E: output_clock_e_div <= pwdata[1:0];
                `ADDR_SECOND_PLL: second_pll_cfg <= pwdata[18:0];
                `ADDR_THIRD_PLL: third_pll_cfg <= pwdata[18:0];
                `ADDR_SUSP: susp     <= pwdata & 32'h0000_073F;
                `ADDR_DIVC: div_c    <= pwdata[6:0];
                `ADDR_DIVD: div_d    <= pwdata[6:0];
                default: begin
                    if (table_hit) begin
                        freq_table[paddr[4:2]] <= pwdata & 32'h0017_FFFF;
                    end else if (diva_hit) begin
                        div_a[paddr[2]] <= pwdata[6:0];
                    end else if (divb_hit) begin
                        div_b[paddr[2]] <= pwdata[6:0];
                    end
                end
            endcase
        end
    end

    // read data registered in the setup cycle, valid through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `ADDR_CTRL:   prdata <= ctrl;
                `ADDR_STATUS: prdata <= {25'h0, divider_register_select, freq_index,
                                         s2_sync[1], sd_sync[1], strap_done};
                `ADDR_OSC:    prdata <= osc;
                `ADDR_OUTPUT_CLOCK_E:   prdata <= {30'h0, output_clock_e_div};
                `ADDR_SECOND_PLL:   prdata <= {13'h0, second_pll_cfg};
                `ADDR_THIRD_PLL:   prdata <= {13'h0, third_pll_cfg};
                `ADDR_SUSP:   prdata <= susp;
                `ADDR_DIVC:   prdata <= {25'h0, div_c};
                `ADDR_DIVD:   prdata <= {25'h0, div_d};
                default: begin
                    if (table_hit) begin
                        prdata <= freq_table[paddr[4:2]];
                    end else if (diva_hit) begin
                        prdata <= {25'h0, div_a[paddr[2]]};
                    end else if (divb_hit) begin
                        prdata <= {25'h0, div_b[paddr[2]]};
                    end else begin
                        prdata <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // power gating: shutdown drops every output, and in full mode the plls too;
    // suspend gates only the programmed set of outputs and plls
    genvar k;
    generate
        for (k = 0; k < 5; k = k + 1) begin : g_output_gate
            assign next_output_enable[k] = ~shut & ~(suspended & susp[k]);
        end
        for (k = 0; k < 3; k = k + 1) begin : g_pll_gate
            assign next_pll_enable[k] = ~chip_down & ctrl[`CTRL_FIRST_PLL_EN + k] &
                                        ~(suspended & susp[`SUSP_PLL_LSB + k]);
        end
    endgenerate

    // pll divider words; the first pll follows the selected table entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_pll_q  <= 8'h01;
            first_pll_p  <= 11'h020;
            second_pll_q <= 8'h01;
            second_pll_p <= 11'h020;
            third_pll_q  <= 8'h01;
            third_pll_p  <= 11'h020;
        end else begin
            first_pll_q  <= entry[`TAB_Q_MSB:`TAB_Q_LSB];
            first_pll_p  <= entry[`TAB_P_MSB:`TAB_P_LSB];
            second_pll_q <= second_pll_cfg[7:0];
            second_pll_p <= second_pll_cfg[18:8];
            third_pll_q  <= third_pll_cfg[7:0];
            third_pll_p  <= third_pll_cfg[18:8];
        end
    end

    // divider words are presented as whole registered words; the analogue
    // divider reloads only at its own terminal count, so no partial value glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_a_divider        <= 7'h00;
            output_b_divider        <= 7'h00;
            output_c_divider        <= 7'h00;
            output_d_divider        <= 7'h00;
            output_e_post_divider   <= `OUTPUT_CLOCK_E_OFF;
            divider_register_select <= 1'b0;
        end else begin
            divider_register_select <= entry[`TAB_DSEL];
            output_a_divider <= div_a[entry[`TAB_DSEL]];
            output_b_divider <= div_b[entry[`TAB_DSEL]];
            output_c_divider <= div_c;
            output_d_divider <= div_d;
            output_e_post_divider <= output_clock_e_div;
        end
    end

    // crystal oscillator settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_load_cap <= 6'h00;
            crystal_drive    <= 2'h0;
            load_cap_bypass  <= 1'b0;
        end else begin
            crystal_load_cap <= osc[`OSC_CAP_MSB:`OSC_CAP_LSB];
            crystal_drive    <= osc[`OSC_DRV_MSB:`OSC_DRV_LSB];
            load_cap_bypass  <= osc[`OSC_BYPASS];
        end
    end

    // registered power controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_enable          <= 3'h0;
            oscillator_enable   <= 1'b0;
            buffered_ref_enable <= 1'b0;
            output_enable       <= 5'h00;
        end else begin
            pll_enable          <= next_pll_enable;
            oscillator_enable   <= ~chip_down;
            buffered_ref_enable <= ~shut & ~(suspended & susp[5]);
            output_enable       <= next_output_enable;
        end
    end

endmodule // pll_frequency_select_control

// ---- test/board_pins.sv ----
// board-side model driving the strap, select and shutdown pins
`timescale 1ns/1ps

module board_pins (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [1:0] strap,
    input  wire       s2_level,
    input  wire       sd_level,
    input  wire       chatter,
    output wire       serial_port_data_pin,
    output wire       serial_port_clock_pin,
    output reg        select_bit_two = 1'b0,
    output reg        shutdown_oe_n = 1'b1
);
    reg [3:0] hold = 4'h0;
    reg       tick = 1'b0;
    // strap levels stay put from reset until well past the capture edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) hold <= 4'h0;
        else if (hold != 4'hF) hold <= hold + 4'h1;
    end
    always @(posedge pclk) begin
        tick <= ~tick;
        select_bit_two <= s2_level;
        shutdown_oe_n <= sd_level;
    end
    // after the strap window the shared pins carry serial traffic
    assign serial_port_data_pin  = (hold == 4'hF && chatter) ? tick : strap[0];
    assign serial_port_clock_pin = (hold == 4'hF && chatter) ? ~tick : strap[1];
endmodule // board_pins

// ---- test/pll_frequency_select_control_asserts.sv ----
// port-level checks of the frequency-select control block
`timescale 1ns/1ps

module pll_select_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        select_bit_two,
    input wire        shutdown_oe_n,
    input wire [7:0]  first_pll_q,
    input wire [7:0]  second_pll_q,
    input wire [6:0]  output_a_divider,
    input wire [6:0]  output_c_divider,
    input wire [1:0]  output_e_post_divider,
    input wire [5:0]  crystal_load_cap,
    input wire [2:0]  pll_enable,
    input wire        oscillator_enable,
    input wire [4:0]  output_enable,
    input wire        divider_register_select
);
    reg [3:0] quiet;
    reg [2:0] age;
    // quiet: cycles without bus access and with steady pins; age: cycles since a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet <= 4'h0;
            age   <= 3'h0;
        end else begin
            if (psel || !$stable(select_bit_two) || !$stable(shutdown_oe_n)) quiet <= 4'h0;
            else if (quiet != 4'hF) quiet <= quiet + 4'h1;
            if (psel && penable && pwrite) age <= 3'h0;
            else if (age != 3'h7) age <= age + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sd_low; !shutdown_oe_n [*4]; endsequence
    sequence s_sd_high; shutdown_oe_n [*5]; endsequence
    property p_oe_off; s_sd_low |-> output_enable == 5'h00; endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs driven in shutdown");
    property p_osc_off; !oscillator_enable |-> pll_enable == 3'h0 && output_enable == 5'h00; endproperty
    a_osc_off: assert property (p_osc_off) else $error("plls live without oscillator");
    property p_osc_run; s_sd_high |-> oscillator_enable; endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator off while enabled");
    property p_held;
        quiet >= 4'h8 |-> $stable(first_pll_q) && $stable(divider_register_select)
            && $stable(output_a_divider) && $stable(pll_enable);
    endproperty
    a_held: assert property (p_held) else $error("settings moved with pins steady");
    property p_e_prog; $changed(output_e_post_divider) |-> age <= 3'h2; endproperty
    a_e_prog: assert property (p_e_prog) else $error("post divider moved unprogrammed");
    property p_second_pll_prog; $changed(second_pll_q) |-> age <= 3'h2; endproperty
    a_second_pll_prog: assert property (p_second_pll_prog) else $error("second pll moved unprogrammed");
    property p_cap_prog; $changed(crystal_load_cap) |-> age <= 3'h2; endproperty
    a_cap_prog: assert property (p_cap_prog) else $error("load cap moved unprogrammed");
    property p_c_prog; $changed(output_c_divider) |-> age <= 3'h2; endproperty
    a_c_prog: assert property (p_c_prog) else $error("divider c moved unprogrammed");
endmodule // pll_select_checker

bind pll_frequency_select_control pll_select_checker i_chk (.*);

// ---- test/test_pll_frequency_select_control.sv ----
// self-checking bench for the frequency-select control block
`timescale 1ns/1ps
`include "pll_select_regs.vh"

module test_pll_frequency_select_control;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg  [1:0]  strap = 2'h1;
    reg         s2_level = 1'b0;
    reg         sd_level = 1'b1;
    reg         chatter = 1'b0;
    wire        pready, pslverr, load_cap_bypass, oscillator_enable, buffered_ref_enable;
    wire        serial_port_data_pin, serial_port_clock_pin, select_bit_two, shutdown_oe_n;
    wire        divider_register_select;
    wire [31:0] prdata;
    wire [7:0]  first_pll_q, second_pll_q, third_pll_q;
    wire [10:0] first_pll_p, second_pll_p, third_pll_p;
    wire [6:0]  output_a_divider, output_b_divider, output_c_divider, output_d_divider;
    wire [5:0]  crystal_load_cap;
    wire [4:0]  output_enable;
    wire [2:0]  pll_enable;
    wire [1:0]  output_e_post_divider, crystal_drive;
    // rows: suspend mode, oe only, s2, shutdown_n, expected q, expected pll enables
    reg  [14:0] rows [0:6] = '{15'h088F, 15'h18AF, 15'h10A8, 15'h208F, 15'h38AF, 15'h588F, 15'h4889};
    reg  [14:0] row;
    reg  [31:0] rd;
    reg  [4:0]  oe_exp;
    integer     failures = 0;
    integer     check_count = 0;
    integer     i;

    pll_frequency_select_control i_dut (.*);
    board_pins i_pins (.*);

    always #12.5 pclk = ~pclk;

    task end_of_test;
        begin
            if (failures == 0 && check_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge pclk);
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (n = 0; n < 16 && pready !== 1'b1; n = n + 1) @(posedge pclk);
            if (n == 16) failures = failures + 1;
            if (n == 16) end_of_test;
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rchk(input string name, input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0000_0000);
            chk(name, exp, rd);
        end
    endtask
    task prog;
        integer j;
        begin
            for (j = 0; j < 8; j = j + 1)
                apb(1'b1, {7'h02, j[2:0], 2'h0}, {11'h000, j[2], 1'b0, 8'h20, j[2:0], 5'h02, j[2:0]});
            apb(1'b1, `ADDR_DIVA_BASE, 32'h0000_0005);
            apb(1'b1, `ADDR_DIVA_BASE + 12'h004, 32'h0000_0009);
            apb(1'b1, `ADDR_DIVB_BASE, 32'h0000_0006);
            apb(1'b1, `ADDR_DIVB_BASE + 12'h004, 32'h0000_000A);
            apb(1'b1, `ADDR_SUSP, 32'h0000_0602);
        end
    endtask

    initial begin
        cyc(12);
        chk("first_pll_q", 32'h0000_0001, first_pll_q);
        chk("first_pll_p", 32'h0000_0020, first_pll_p);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("ctrl", `ADDR_CTRL, `CTRL_RESET);
        rchk("osc", `ADDR_OSC, `OSC_RESET);
        rchk("output_clock_e", `ADDR_OUTPUT_CLOCK_E, 32'h0000_0002);
        rchk("second_pll", `ADDR_SECOND_PLL, `TAB_RESET);
        rchk("table", `ADDR_TABLE_BASE + 12'h01C, `TAB_RESET);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        rchk("unmapped", 12'h0FC, 32'h0000_0000);
        chk("pslverr", 32'h0000_0000, pslverr);
        prog;
        for (i = 0; i < 7; i = i + 1) begin
            row = rows[i];
            apb(1'b1, `ADDR_CTRL, {27'h0000000, 3'h7, row[14:13]});
            s2_level <= row[12];
            sd_level <= row[11];
            cyc(8);
            chk("first_pll_q", row[10:3], first_pll_q);
            chk("first_pll_p", {8'h20, row[5:3]}, first_pll_p);
            chk("divider_register_select", row[5], divider_register_select);
            chk("output_a_divider", row[5] ? 7'h09 : 7'h05, output_a_divider);
            chk("output_b_divider", row[5] ? 7'h0A : 7'h06, output_b_divider);
            chk("pll_enable", row[2:0], pll_enable);
            chk("oscillator_enable", row[2:0] != 3'h0, oscillator_enable);
            if (!row[11]) chk("output_enable", 5'h00, output_enable);
            if (row[14] && !row[12]) chk("output_b_enable", 1'b0, output_enable[1]);
            oe_exp = row[11] ? ((row[14] && !row[12]) ? 5'h1D : 5'h1F) : 5'h00;
            chk("output_enable", oe_exp, output_enable);
            chk("buffered_ref_enable", row[11], buffered_ref_enable);
        end
        apb(1'b1, `ADDR_OSC, 32'h0000_1225);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, `ADDR_OUTPUT_CLOCK_E, i);
            cyc(2);
            chk("output_e_post_divider", i, output_e_post_divider);
        end
        chk("crystal_load_cap", 6'h25, crystal_load_cap);
        chk("crystal_drive", 2'h2, crystal_drive);
        chk("load_cap_bypass", 1'b1, load_cap_bypass);
        apb(1'b1, `ADDR_SECOND_PLL, 32'h0003_ABC4);
        apb(1'b1, `ADDR_THIRD_PLL, 32'h0005_553E);
        apb(1'b1, `ADDR_DIVC, 32'h0000_007F);
        apb(1'b1, `ADDR_DIVD, 32'h0000_0033);
        cyc(2);
        chk("second_pll", {8'hC4, 11'h3AB}, {second_pll_q, second_pll_p});
        chk("third_pll", {8'h3E, 11'h555}, {third_pll_q, third_pll_p});
        chk("output_c_divider", 7'h7F, output_c_divider);
        chk("output_d_divider", 7'h33, output_d_divider);
        chatter <= 1'b1;
        cyc(20);
        chk("first_pll_q", 8'h11, first_pll_q);
        chatter <= 1'b0;
        strap <= 2'h2;
        s2_level <= 1'b1;
        presetn <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
        prog;
        cyc(8);
        chk("first_pll_q", 8'h16, first_pll_q);
        rchk("status", `ADDR_STATUS, 32'h0000_0077);
        end_of_test;
    end
endmodule // test_pll_frequency_select_control
